// ### dv/pump_img_chk.sv
`timescale 1ns/1ps
// watches both ends of the cyclic exchange
module pump_img_chk (
  input wire logic                                    mclk,
  input wire logic                                    rst_b,
  input wire logic [pump_img_pkg::OUT_BYTES-1:0][7:0] outByte,
  input wire logic                                    outValid,
  input wire logic [pump_img_pkg::IN_BYTES-1:0][7:0]  inByte,
  input wire logic                                    inValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic pulseCmd; // command byte 1 selects pulse mode
  logic modeCmd;  // command byte 1 is a legal mode order
  logic sameCmd;  // answer present and byte 1 a legal mode order
  assign pulseCmd = outByte[0] inside {8'h21, 8'hA1, 8'hC1};
  assign modeCmd  = pulseCmd || (outByte[0] inside {8'h02, 8'h03, 8'h04});
  // answer with a mode order; the assertions add the old/new accepted byte agreement that hides image latency
  always_comb sameCmd = inValid && modeCmd;
  a_answer_timing: assert property (outValid |=> inValid ##1 !inValid)
    else $error("image answer not one cycle after request");
  a_image_hold: assert property (!inValid |-> $stable(inByte))
    else $error("image changed between exchanges");
  a_mode_echo: assert property (sameCmd && outByte[0] == $past(outByte[0], 2)
    |-> inByte[0][2:0] == outByte[0][2:0]) else $error("mode status wrong");
  a_ratio_echo: assert property (sameCmd && pulseCmd && outByte[0] == $past(outByte[0],2)
    |-> inByte[0][6:5] == outByte[0][6:5]) else $error("ratio status wrong");
  a_reserved_zero: assert property (inValid |-> inByte[0][4:3] == 2'h0 && !inByte[1][3]
    && !inByte[4][5] && inByte[11:10] == 16'h0000) else $error("reserved bit set");
  a_alarm_fixed: assert property (inValid |-> inByte[4][7])
    else $error("alarm byte fixed bit low");
  a_reset_echo: assert property (outValid |=> inByte[1][5] == $past(outByte[1][7]))
    else $error("reset confirm mismatch");
  a_alarm_sum: assert property (inValid |-> inByte[1][6] ==
    (|(inByte[4] & pump_img_pkg::ALARM_A_USED) || |inByte[5])) else $error("alarm sum wrong");
  a_trip_sum: assert property (inValid |-> inByte[1][7] ==
    (|(inByte[4] & pump_img_pkg::TRIP_MASK_A) || |(inByte[5] & pump_img_pkg::TRIP_MASK_B)))
    else $error("trip sum wrong");
  a_power_range: assert property (inValid |-> inByte[6] < 8'h04 && inByte[7] < 8'h04)
    else $error("decimal power out of range");
endmodule // pump_img_chk

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;   // system clock
  logic        rst_b = 1'b0;  // sync reset, active low
  logic [7:0]  addr = 8'h00;  // software port
  logic [7:0]  wrData = 8'h00;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic [7:0]  rdData;
  logic        online = 1'b0, busMode = 1'b0, calibrated = 1'b0, flowMeter = 1'b0;
  logic        strokeDone = 1'b0, batchComplete = 1'b0;
  logic [7:0]  alarmA = 8'h00;
  logic [6:0]  alarmB = 7'h00;
  logic [15:0] strokeFreq = 16'h0011, flowDesired = 16'h0022, flowActual = 16'h0033;
  logic [15:0] remStrokes = 16'h0044, remLitres = 16'h0055;
  logic [15:0] strokeCount = 16'h0066, volumeCount = 16'h0077;
  logic [1:0]  flowPower = 2'h2, cntPower = 2'h3;
  logic [2:0]  modeSel;
  logic        runEnable, strokeReq, batchStart, singleStroke;
  logic [15:0] batchSize, setpoint, driveSpeed;
  logic [7:0]  v;             // last read byte
  int          fails = 0, cmp_count = 0, starts = 0;
  // mode orders and the bytes 3-4 value each shows when calibrated with a meter
  logic [7:0]  cm [6] = '{8'h21, 8'hA1, 8'hC1, 8'h02, 8'h03, 8'h04};
  logic [15:0] ev [6] = '{16'h0102, 16'h0102, 16'h0102, 16'h0033, 16'h0055, 16'h0011};

  always #25 mclk = ~mclk;
  // count batch start pulses
  always @(posedge mclk) if (batchStart === 1'b1) starts++;

  pump_img_if i_pump_img_if ();
  pump_img_device #(.STROKE_CYC(40)) i_pump_img_device (.mclk, .rst_b, .ce(1'b1),
    .bus(i_pump_img_if), .online, .busMode, .calibrated, .flowMeter, .strokeDone,
    .batchComplete, .alarmA, .alarmB, .strokeFreq, .flowDesired, .flowActual, .remStrokes,
    .remLitres, .strokeCount, .volumeCount, .flowPower, .cntPower, .modeSel, .runEnable,
    .strokeReq, .batchStart, .batchSize, .setpoint, .driveSpeed, .singleStroke);
  pump_img_master i_pump_img_master (.mclk, .rst_b, .ce(1'b1), .addr, .wrData, .wrStb,
    .rdStb, .rdData, .bus(i_pump_img_if));
  pump_img_chk i_pump_img_chk (.mclk, .rst_b, .outByte(i_pump_img_if.outByte),
    .outValid(i_pump_img_if.outValid), .inByte(i_pump_img_if.inByte),
    .inValid(i_pump_img_if.inValid));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1;
    v = rdData;
  endtask
  // image byte n (counted from 1) under a mask
  task automatic img(input int n, input logic [7:0] m, input logic [7:0] e);
    rd(pump_img_pkg::REG_IN_BASE + 8'(n - 1));
    check(16'(v & m), 16'(e));
  endtask
  // long enough for an order to reach the device and its image to come back
  task automatic xw;
    repeat (50) @(posedge mclk);
    #1;
  endtask
  // byte 2 last, so a start never overtakes its settings
  task automatic cmd(input logic [7:0] b1, input logic [7:0] b2, input logic [15:0] f);
    wr(8'h00, b1);
    wr(8'h02, f[15:8]);
    wr(8'h03, f[7:0]);
    wr(8'h01, b2);
    xw();
  endtask
  task automatic stroke;
    @(posedge mclk);
    strokeDone <= 1'b1;
    @(posedge mclk);
    strokeDone <= 1'b0;
    #1;
  endtask

  task automatic s_status;
    @(posedge mclk);
    online <= 1'b1;
    busMode <= 1'b1;
    alarmA <= 8'h09;
    xw();
    img(2, 8'hFF, 8'hD1);
    img(5, 8'hFF, 8'h89);
    img(9, 8'hFF, 8'h00);
    img(10, 8'hFF, 8'h66);
    img(7, 8'hFF, 8'h02);
    img(8, 8'hFF, 8'h03);
    alarmA <= 8'h22;
    alarmB <= 7'h02;
    xw();
    img(2, 8'hFF, 8'h51);
    img(5, 8'hFF, 8'h82);
    img(6, 8'hFF, 8'h02);
    img(11, 8'hFF, 8'h00);
    busMode <= 1'b0;
    xw();
    img(2, 8'h10, 8'h00);
    busMode <= 1'b1;
  endtask
  task automatic s_modes;
    calibrated <= 1'b1;
    flowMeter <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cmd(cm[i], 8'h00, 16'h0102);
      img(1, (i < 3) ? 8'hFF : 8'h87, cm[i] | 8'h80);
      img(3, 8'hFF, ev[i][15:8]);
      img(4, 8'hFF, ev[i][7:0]);
      check(16'(modeSel), 16'(cm[i][2:0]));
    end
    img(10, 8'hFF, 8'h77);
    wr(8'h00, 8'h55);
    xw();
    check(16'(modeSel), 16'h0004);
    rd(pump_img_pkg::REG_STATUS);
    check(16'(v & 8'h04), 16'h0004);
  endtask
  task automatic s_ctrl;
    flowMeter <= 1'b0;
    cmd(pump_img_pkg::CMD_EXT, pump_img_pkg::CB2_EXT_ON, 16'h0032);
    check(16'(runEnable), 16'h0001);
    wr(8'h01, 8'h03);
    xw();
    check(16'(runEnable), 16'h0000);
    cmd(pump_img_pkg::CMD_ANALOG, 8'h00, 16'h000A);
    check(16'(runEnable), 16'h0001);
    check(setpoint, 16'h000A);
    img(4, 8'hFF, 8'h22);
    check({driveSpeed[14:0], singleStroke}, 16'h0015);
    cmd(pump_img_pkg::CMD_ANALOG, 8'h20, 16'h000A);
    check({driveSpeed[14:0], singleStroke}, 16'h003D);
    calibrated <= 1'b0;
    cmd(pump_img_pkg::CMD_ANALOG, 8'h20, 16'h0032);
    check({driveSpeed[14:0], singleStroke}, 16'h0064);
    img(4, 8'hFF, 8'h11);
    wr(8'h01, 8'h84);
    xw();
    check(16'(runEnable), 16'h0000);
    img(2, 8'h20, 8'h20);
    wr(8'h01, 8'h00);
    xw();
    img(2, 8'h20, 8'h00);
  endtask
  task automatic s_pulse;
    cmd(pump_img_pkg::CMD_PULSE_NOMEM, 8'h00, 16'h0002);
    check(16'(strokeReq), 16'h0000);
    wr(pump_img_pkg::REG_PULSE, 8'h01);
    xw();
    stroke();
    check(16'(strokeReq), 16'h0001);
    stroke();
    check(16'(strokeReq), 16'h0000);
    repeat (20) @(posedge mclk);
    img(2, 8'h02, 8'h02);
    xw();
    img(2, 8'h02, 8'h00);
    wr(8'h01, 8'h01);
    xw();
    stroke();
    stroke();
    xw();
    check(16'(strokeReq), 16'h0000);
    wr(8'h01, 8'h00);
    // memory on: second big factor saturates the pending count
    cmd(pump_img_pkg::CMD_PULSE_MEM, 8'h00, 16'hFFFF);
    wr(pump_img_pkg::REG_PULSE, 8'h01);
    xw();
    wr(pump_img_pkg::REG_PULSE, 8'h01);
    xw();
    img(6, 8'h80, 8'h80);
    wr(8'h01, 8'h80);
    xw();
    img(6, 8'h80, 8'h00);
    wr(8'h01, 8'h00);
  endtask
  task automatic s_batch;
    wr(8'h04, 8'h40);
    cmd(pump_img_pkg::CMD_BATCH, pump_img_pkg::CB2_BATCH_START, 16'h0007);
    check(batchSize, 16'h0007);
    check(driveSpeed, 16'h0040);
    img(4, 8'hFF, 8'h44);
    @(posedge mclk);
    batchComplete <= 1'b1;
    @(posedge mclk);
    batchComplete <= 1'b0;
    xw();
    img(2, 8'h04, 8'h04);
    wr(8'h01, 8'h00);
    xw();
    img(2, 8'h04, 8'h04);
    wr(8'h01, pump_img_pkg::CB2_BATCH_START);
    xw();
    img(2, 8'h04, 8'h00);
    check(16'(starts), 16'h0002);
  endtask
  // mid-run reset: mode and command state fall back to no selection
  task automatic s_reset;
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    check({modeSel, runEnable, batchSize[11:0]}, 16'h0000);
    xw();
    img(1, 8'hFF, 8'h00);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    s_status();
    s_modes();
    s_ctrl();
    s_pulse();
    s_batch();
    s_reset();
    conclude();
  end
  // hang guard, well beyond the roughly 1800 cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end
endmodule // testbench

// ### hdl/pulse_stretch.sv
`timescale 1ns/1ps
// retriggerable one-shot: busy for CYC cycles after the last trigger
module pulse_stretch #(
  parameter int CYC = 4
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic trig,
  output logic      busy
);
  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LOAD = W'(CYC);

  logic [W-1:0] cnt_q;  // cycles left

  // reload on trigger, otherwise count down to zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (trig) begin
        cnt_q <= LOAD;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

  assign busy = (cnt_q != '0);
endmodule // pulse_stretch

// ### hdl/pump_img_device.sv
//Function
// - present full twelve-byte status image each exchange
// - byte 1 bits 2..0 report dosing mode
// - byte 1 ratio bits, calibrated bit, reserved zero
// - byte 2 bit 0 pump online
// - byte 2 bit 1 high 200 ms per stroke
// - batch finished sticky until next batch start
// - byte 2 bit 4 bus versus manual mode
// - byte 2 bit 5 echoes master reset bit
// - byte 2 bit 6 ORs all alarms
// - byte 2 bit 7 ORs switch-off trips only
// - bytes 3-4 value chosen by mode, calibration
// - byte 7 decimal power zero to three
// - alarm byte 5 layout, bit 7 one
// - alarm byte 6 layout incl pulse overflow
// - bytes 9-10 stroke or volume counter, byte 8 power
// - master selects pulse mode with 21h, A1h, C1h
// - pulse factor strokes per input pulse
// - pulse only on rising command bit 0
// - analog mode 2h, bytes 3-4 frequency or flow
// - analog stop while command bit 2 set
// - speed control bit, 30 percent floor
// - batch setup 3h, start with Ah
// - external mode 4h, run while byte 2 is 2h
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module pump_img_device #(
  parameter int STROKE_CYC = pump_img_pkg::STROKE_PULSE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  pump_img_if.device       bus,
  input  wire logic        online,
  input  wire logic        busMode,
  input  wire logic        calibrated,
  input  wire logic        flowMeter,
  input  wire logic        strokeDone,
  input  wire logic        batchComplete,
  input  wire logic [7:0]  alarmA,
  input  wire logic [6:0]  alarmB,
  input  wire logic [15:0] strokeFreq,
  input  wire logic [15:0] flowDesired,
  input  wire logic [15:0] flowActual,
  input  wire logic [15:0] remStrokes,
  input  wire logic [15:0] remLitres,
  input  wire logic [15:0] strokeCount,
  input  wire logic [15:0] volumeCount,
  input  wire logic [1:0]  flowPower,
  input  wire logic [1:0]  cntPower,
  output logic [2:0]       modeSel,
  output logic             runEnable,
  output logic             strokeReq,
  output logic             batchStart,
  output logic [15:0]      batchSize,
  output logic [15:0]      setpoint,
  output logic [15:0]      driveSpeed,
  output logic             singleStroke
);
  logic [pump_img_pkg::OUT_BYTES-1:0][7:0] ob_q;     // last accepted master image
  logic [pump_img_pkg::IN_BYTES-1:0][7:0]  img_d;    // image being assembled
  logic [pump_img_pkg::IN_BYTES-1:0][7:0]  img_q;    // image shown to the master
  logic                                    inVal_q;  // answer strobe
  logic [15:0]                             pend_q;   // strokes still owed
  logic                                    ovfl_q;   // pulse memory overflow
  logic                                    done_q;   // batch finished
  logic                                    active_q; // batch running
  logic                                    strokeSig;
  logic [15:0]                             factor;
  logic [16:0]                             sum;
  logic [15:0]                             dosVal;
  logic [15:0]                             freqReq;
  logic                                    pulseEdge;
  logic                                    startEdge;
  logic                                    memOn;
  logic                                    trip;
  logic                                    anyAlarm;
  logic [7:0]                              alarmByteA;
  logic [7:0]                              alarmByteB;

  // decode of the accepted command image
  assign modeSel = ob_q[0][pump_img_pkg::CB1_MODE_LSB +: 3];
  assign memOn   = ob_q[0][pump_img_pkg::CB1_MEMORY];
  assign factor  = {ob_q[2], ob_q[3]};
  assign setpoint = factor;

  // edges are judged between consecutive exchanges, not cycles
  assign pulseEdge = bus.outValid && (bus.outByte[0][2:0] == pump_img_pkg::MODE_PULSE)
                   && bus.outByte[1][pump_img_pkg::CB2_PULSE]
                   && !ob_q[1][pump_img_pkg::CB2_PULSE];
  assign startEdge = bus.outValid && (bus.outByte[0][2:0] == pump_img_pkg::MODE_BATCH)
                   && (bus.outByte[1] == pump_img_pkg::CB2_BATCH_START)
                   && (ob_q[1] != pump_img_pkg::CB2_BATCH_START);

  // capture the master image on each exchange
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ob_q <= '0;
    end else if (ce && bus.outValid) begin
      ob_q <= bus.outByte;
    end
  end

  // pending stroke count; a stroke done and a new pulse may coincide
  assign sum = {1'b0, pend_q} + {1'b0, factor} - {16'h0000, strokeDone && pend_q != 16'h0000};
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pend_q <= '0;
    end else if (ce) begin
      if (modeSel != pump_img_pkg::MODE_PULSE) begin
        pend_q <= '0;
      end else if (pulseEdge && (memOn || pend_q == 16'h0000)) begin
        // memory off: a pulse during strokes is dropped
        pend_q <= sum[16] ? 16'hFFFF : sum[15:0];
      end else if (strokeDone && pend_q != 16'h0000) begin
        pend_q <= pend_q - 16'h0001;
      end
    end
  end

  // overflow flag, set wins over the master's reset request
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ovfl_q <= 1'b0;
    end else if (ce) begin
      if (pulseEdge && memOn && sum[16]) begin
        ovfl_q <= 1'b1;
      end else if (ob_q[1][pump_img_pkg::CB2_RESET]) begin
        ovfl_q <= 1'b0;
      end
    end
  end

  // batch state: finished flag is sticky until a new start
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      done_q   <= 1'b0;
      active_q <= 1'b0;
    end else if (ce) begin
      if (batchComplete) begin
        done_q   <= 1'b1;
        active_q <= 1'b0;
      end else if (startEdge) begin
        done_q   <= 1'b0;
        active_q <= 1'b1;
      end else if (modeSel != pump_img_pkg::MODE_BATCH) begin
        active_q <= 1'b0;
      end
    end
  end

  assign batchStart = ce && startEdge && !batchComplete;
  assign batchSize  = factor;
  assign strokeReq  = busMode && (pend_q != 16'h0000);

  // run gate per mode
  always_comb begin
    runEnable = 1'b0;
    freqReq   = factor;
    case (modeSel)
      pump_img_pkg::MODE_PULSE:  runEnable = 1'b1;
      pump_img_pkg::MODE_ANALOG: runEnable = !ob_q[1][pump_img_pkg::CB2_STOP];
      pump_img_pkg::MODE_BATCH: begin
        runEnable = active_q;
        freqReq   = {8'h00, ob_q[4]};
      end
      pump_img_pkg::MODE_EXT: runEnable = (ob_q[1] == pump_img_pkg::CB2_EXT_ON);
      default: runEnable = 1'b0;
    endcase
    runEnable = runEnable && busMode;
  end

  // speed control below the floor falls back to single strokes at the floor
  always_comb begin
    driveSpeed   = freqReq;
    singleStroke = 1'b1;
    if (ob_q[1][pump_img_pkg::CB2_SPEED]) begin
      if (freqReq < pump_img_pkg::SPEED_MIN_PCT) begin
        driveSpeed = pump_img_pkg::SPEED_MIN_PCT;
      end else begin
        singleStroke = 1'b0;
      end
    end
  end

  // stroke signal stretched so a slow master still sees it
  pulse_stretch #(.CYC(STROKE_CYC)) i_pulse_stretch (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .trig  (strokeDone),
    .busy  (strokeSig)
  );

  // alarm bytes; unused positions forced to zero, except byte 5 bit 7, which is fixed at one
  assign alarmByteA = (alarmA & pump_img_pkg::ALARM_A_USED)
                    | pump_img_pkg::ALARM_A_FIXED;
  assign alarmByteB = {ovfl_q, alarmB};
  assign anyAlarm   = |(alarmByteA & pump_img_pkg::ALARM_A_USED) || |alarmByteB;
  assign trip       = |(alarmByteA & pump_img_pkg::TRIP_MASK_A)
                   || |(alarmByteB & pump_img_pkg::TRIP_MASK_B);

  // dosing value by mode and calibration
  always_comb begin
    case (modeSel)
      pump_img_pkg::MODE_PULSE:  dosVal = factor;
      pump_img_pkg::MODE_ANALOG:
        dosVal = !calibrated ? strokeFreq : (flowMeter ? flowActual : flowDesired);
      pump_img_pkg::MODE_BATCH:  dosVal = calibrated ? remLitres : remStrokes;
      pump_img_pkg::MODE_EXT:    dosVal = strokeFreq;
      default:                   dosVal = 16'h0000;
    endcase
  end

  // image assembly; anything not written stays zero
  always_comb begin
    img_d = '0;
    img_d[0][2:0] = modeSel;
    img_d[0][pump_img_pkg::SB1_RATIO_LSB +: 2] =
      ob_q[0][pump_img_pkg::CB1_RATIO_LSB +: 2];
    img_d[0][pump_img_pkg::SB1_CAL] = calibrated;
    img_d[1][pump_img_pkg::SB2_ONLINE]     = online;
    img_d[1][pump_img_pkg::SB2_STROKE]     = strokeSig;
    img_d[1][pump_img_pkg::SB2_BATCH_DONE] = done_q;
    img_d[1][pump_img_pkg::SB2_BUS]        = busMode;
    img_d[1][pump_img_pkg::SB2_RESET_ACK]  =
      bus.outByte[1][pump_img_pkg::CB2_RESET];
    img_d[1][pump_img_pkg::SB2_ALARM]      = anyAlarm;
    img_d[1][pump_img_pkg::SB2_TRIP]       = trip;
    img_d[2] = dosVal[15:8];
    img_d[3] = dosVal[7:0];
    img_d[4] = alarmByteA;
    img_d[5] = alarmByteB;
    img_d[6] = {6'h00, flowPower};
    img_d[7] = {6'h00, cntPower};
    img_d[8] = calibrated ? volumeCount[15:8] : strokeCount[15:8];
    img_d[9] = calibrated ? volumeCount[7:0] : strokeCount[7:0];
  end

  // whole image latched per exchange and answered next cycle;
  // the answer strobe freezes with ce so a held exchange is still answered
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      img_q   <= '0;
      inVal_q <= 1'b0;
    end else if (ce) begin
      inVal_q <= bus.outValid;
      if (bus.outValid) begin
        img_q <= img_d;
      end
    end
  end

  assign bus.inByte  = img_q;
  assign bus.inValid = inVal_q;
endmodule // pump_img_device

// ### hdl/pump_img_if.sv
`timescale 1ns/1ps
interface pump_img_if;
  logic [pump_img_pkg::OUT_BYTES-1:0][7:0] outByte;  // master image, index 0 is byte 1
  logic                                    outValid; // one-cycle exchange strobe
  logic [pump_img_pkg::IN_BYTES-1:0][7:0]  inByte;   // device image, index 0 is byte 1
  logic                                    inValid;  // one cycle after outValid

  modport device (input outByte, input outValid, output inByte, output inValid);
  modport master (output outByte, output outValid, input inByte, input inValid);
endinterface

// ### hdl/pump_img_master.sv
`timescale 1ns/1ps
module pump_img_master (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic [7:0]      rdData,
  pump_img_if.master      bus
);
  logic [pump_img_pkg::OUT_BYTES-1:0][7:0] outReg_q;  // software command bytes
  logic [pump_img_pkg::OUT_BYTES-1:0][7:0] snap_q;    // bytes on the link
  logic [pump_img_pkg::IN_BYTES-1:0][7:0]  inReg_q;   // last device image
  logic [7:0]                              tmr_q;     // exchange timer
  logic                                    xchg_q;    // exchange strobe
  logic                                    pend_q;    // pulse queued
  logic                                    high_q;    // pulse bit sent high
  logic                                    fresh_q;   // new image arrived
  logic                                    err_q;     // illegal mode refused
  logic [7:0]                              rd_q;
  logic                                    legal;
  logic                                    statRd;
  logic                                    tick;

  // only the documented mode codes may reach byte 1
  always_comb begin
    case (wrData)
      pump_img_pkg::CMD_PULSE_NOMEM,
      pump_img_pkg::CMD_PULSE_MEM,
      pump_img_pkg::CMD_PULSE_TRANS: legal = 1'b1;
      pump_img_pkg::CMD_ANALOG:      legal = 1'b1;
      pump_img_pkg::CMD_BATCH:       legal = 1'b1;
      pump_img_pkg::CMD_EXT:         legal = 1'b1;
      pump_img_pkg::CMD_NONE:        legal = 1'b1;
      default:                       legal = 1'b0;
    endcase
  end

  assign statRd = rdStb && (addr == pump_img_pkg::REG_STATUS);
  assign tick   = (tmr_q == pump_img_pkg::EXCH_CYC - 8'h01);

  // command registers; bytes 2..5 carry stop, start, factor, frequency
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      outReg_q <= '0;
    end else if (ce && wrStb
                 && addr < pump_img_pkg::REG_OUT_BASE + 8'(pump_img_pkg::OUT_BYTES)) begin
      if (addr != pump_img_pkg::REG_OUT_BASE || legal) begin
        outReg_q[addr[2:0]] <= wrData;
      end
    end
  end

  // refused mode write flag; a new refusal wins over the clearing read
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      err_q <= 1'b0;
    end else if (ce) begin
      if (wrStb && addr == pump_img_pkg::REG_OUT_BASE && !legal) begin
        err_q <= 1'b1;
      end else if (statRd) begin
        err_q <= 1'b0;
      end
    end
  end

  // free-running exchange timer; the strobe freezes with ce, else a queued
  // pulse already taken from pend_q would never reach the device
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tmr_q  <= '0;
      xchg_q <= 1'b0;
    end else if (ce) begin
      tmr_q  <= tick ? 8'h00 : tmr_q + 8'h01;
      xchg_q <= tick;
    end
  end

  // pulse helper: bit 0 high for one exchange, low for the next
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      high_q <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        high_q <= pend_q && !high_q;
      end
      if (wrStb && addr == pump_img_pkg::REG_PULSE) begin
        pend_q <= 1'b1;
      end else if (tick && !high_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  // snapshot sent with the strobe so the image is coherent
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      snap_q <= '0;
    end else if (ce && tick) begin
      snap_q    <= outReg_q;
      snap_q[1] <= outReg_q[1] | {7'h00, pend_q && !high_q};
    end
  end

  // device image capture; arrival wins over the clearing read
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      inReg_q <= '0;
      fresh_q <= 1'b0;
    end else if (ce) begin
      if (bus.inValid) begin
        inReg_q <= bus.inByte;
        fresh_q <= 1'b1;
      end else if (statRd) begin
        fresh_q <= 1'b0;
      end
    end
  end

  // read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_q <= '0;
    end else if (ce) begin
      rd_q <= 8'h00;
      if (rdStb) begin
        if (addr < pump_img_pkg::REG_OUT_BASE + 8'(pump_img_pkg::OUT_BYTES)) begin
          rd_q <= outReg_q[addr[2:0]];
        end else if (addr >= pump_img_pkg::REG_IN_BASE
                     && addr < pump_img_pkg::REG_IN_BASE + 8'(pump_img_pkg::IN_BYTES)) begin
          rd_q <= inReg_q[addr[3:0]];
        end else if (statRd) begin
          rd_q <= {5'h00, err_q, pend_q, fresh_q};
        end
      end
    end
  end

  assign rdData       = rd_q;
  assign bus.outByte  = snap_q;
  assign bus.outValid = xchg_q;
endmodule // pump_img_master

// ### hdl/pump_img_pkg.sv
package pump_img_pkg;
  // image sizes in bytes
  localparam int OUT_BYTES = 5;
  localparam int IN_BYTES  = 12;

  // mode field codes (status byte 1 bits 2..0, command byte 1 bits 2..0)
  localparam logic [2:0] MODE_NONE   = 3'h0;
  localparam logic [2:0] MODE_PULSE  = 3'h1;
  localparam logic [2:0] MODE_ANALOG = 3'h2;
  localparam logic [2:0] MODE_BATCH  = 3'h3;
  localparam logic [2:0] MODE_EXT    = 3'h4;

  // command byte 1 layout
  localparam int CB1_MODE_LSB  = 0;
  localparam int CB1_RATIO_LSB = 5;
  localparam int CB1_MEMORY    = 7;

  // legal command byte 1 values
  localparam logic [7:0] CMD_PULSE_NOMEM = 8'h21;
  localparam logic [7:0] CMD_PULSE_MEM   = 8'hA1;
  localparam logic [7:0] CMD_PULSE_TRANS = 8'hC1;
  localparam logic [7:0] CMD_ANALOG      = 8'h02;
  localparam logic [7:0] CMD_BATCH       = 8'h03;
  localparam logic [7:0] CMD_EXT         = 8'h04;
  localparam logic [7:0] CMD_NONE        = 8'h00;

  // command byte 2 whole values and bits
  localparam logic [7:0] CB2_BATCH_START = 8'h0A;
  localparam logic [7:0] CB2_EXT_ON      = 8'h02;
  localparam int CB2_PULSE = 0;
  localparam int CB2_STOP  = 2;
  localparam int CB2_SPEED = 5;
  localparam int CB2_RESET = 7;

  // status byte 1 and 2 bit positions
  localparam int SB1_RATIO_LSB  = 5;
  localparam int SB1_CAL        = 7;
  localparam int SB2_ONLINE     = 0;
  localparam int SB2_STROKE     = 1;
  localparam int SB2_BATCH_DONE = 2;
  localparam int SB2_BUS        = 4;
  localparam int SB2_RESET_ACK  = 5;
  localparam int SB2_ALARM      = 6;
  localparam int SB2_TRIP       = 7;

  // alarm byte layout
  localparam logic [7:0] ALARM_A_USED   = 8'h5F;
  localparam logic [7:0] ALARM_A_FIXED  = 8'h80;
  localparam logic [7:0] TRIP_MASK_A    = 8'h59;
  localparam logic [7:0] TRIP_MASK_B    = 8'h1D;
  localparam int         ALARM_B_OVFL   = 7;

  // speed control floor in percent
  localparam logic [15:0] SPEED_MIN_PCT = 16'h001E;

  // stroke signal length
  localparam int CLK_HZ          = 20_000_000;
  localparam int STROKE_PULSE_MS = 200;
  localparam int STROKE_PULSE_CYC = STROKE_PULSE_MS * (CLK_HZ / 1000);

  // controller register map and exchange period
  localparam logic [7:0] REG_OUT_BASE = 8'h00;
  localparam logic [7:0] REG_PULSE    = 8'h08;
  localparam logic [7:0] REG_IN_BASE  = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h20;
  localparam logic [7:0] EXCH_CYC     = 8'h10;
  localparam int STAT_FRESH = 0;
  localparam int STAT_PEND  = 1;
  localparam int STAT_ERR   = 2;
endpackage
